// >>> rtl/aps_top.sv
// alternate pin function select register and pin routing
// ----------------------------------------
// Summary of operation
// - small package: rx/data on RC5 when bit 7 clear, RA1 when set
// - large package: rx/data on RB5 when bit 7 clear, RC5 when set
// - small package: slave select on RC3 when bit 5 clear, RA3 when set
// - large package: bit 5 reads zero, slave select fixed on RC6
// - bit 4 unimplemented, reads zero, writes ignored
// - timer gate from RA4 when bit 3 clear, RA3 when set
// - bit 2 picks transmit/clock pin, RC4 when clear (small package)
// ----------------------------------------
`timescale 1ns/1ps
`default_nettype none
module aps_top
  import aps_pkg::*;
#(
  parameter int SMALL_PKG = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // pads: level from pin, drive and enable to pin, port logic defaults
  input wire logic [APS_PIN_N-1:0] pin_in,
  input wire logic [APS_PIN_N-1:0] port_out,
  input wire logic [APS_PIN_N-1:0] port_oe_n,
  output var aps_pads_t pads,
  // serial receive/data line
  input wire logic serial_receive_line_out,
  input wire logic serial_receive_line_oe_n,
  output logic serial_receive_line_in,
  // serial transmit/clock line
  input wire logic serial_transmit_line_out,
  input wire logic serial_transmit_line_oe_n,
  output logic serial_transmit_line_in,
  // spi data out, slave select, timer gate
  input wire logic spi_sdo_out,
  input wire logic spi_sdo_oe_n,
  output logic spi_ss_in,
  output logic timer_gate_in
);

  // ----------------------------------------
  // checks and constants
  // ----------------------------------------
  if (SMALL_PKG != 0 && SMALL_PKG != 1) begin : g_chk
    $error("SMALL_PKG must be 0 or 1");
  end

  localparam logic [7:0] WR_MASK = (SMALL_PKG == 1) ? APS_MASK_SMALL : APS_MASK_LARGE;
  localparam int RX0 = (SMALL_PKG == 1) ? PIN_RC5 : PIN_RB5;
  localparam int RX1 = (SMALL_PKG == 1) ? PIN_RA1 : PIN_RC5;
  localparam int SDO0 = (SMALL_PKG == 1) ? PIN_RC2 : PIN_RC7;
  localparam int SPI_SERIAL_OUT = (SMALL_PKG == 1) ? PIN_RA4 : PIN_RC7;
  localparam int SS0 = (SMALL_PKG == 1) ? PIN_RC3 : PIN_RC6;
  localparam int SS1 = (SMALL_PKG == 1) ? PIN_RA3 : PIN_RC6;
  localparam int TX0 = (SMALL_PKG == 1) ? PIN_RC4 : PIN_RB7;
  localparam int TX1 = (SMALL_PKG == 1) ? PIN_RA0 : PIN_RC4;

  // pick one of two pin indices by a select bit
  function automatic int pick(input logic s, input int i0, input int i1);
    pick = s ? i1 : i0;
  endfunction

  // ----------------------------------------
  // pin input synchroniser
  // ----------------------------------------
  logic [APS_PIN_N-1:0] pin_s;

  aps_sync2 #(.W(APS_PIN_N)) u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .d(pin_in),
    .q(pin_s)
  );

  aps_state_t st;
  aps_state_t next_st;
  logic hit;
  logic req;

  assign hit = (avs_address == APS_SEL_OFF);
  assign req = avs_read | avs_write;

  // ----------------------------------------
  // next state: bus slave and routing
  // ----------------------------------------
  always_comb begin
    int rx_i;
    int sdo_i;
    int ss_i;
    int tg_i;
    int tx_i;
    rx_i = 0;
    sdo_i = 0;
    ss_i = 0;
    tg_i = 0;
    tx_i = 0;
    next_st = st;
    next_st.run = 1'b1;
    // one wait cycle, then answer for one cycle
    next_st.waitrequest = !(req && st.waitrequest);
    if (avs_write && !st.waitrequest && hit && avs_byteenable[0]) begin
      next_st.sel = avs_writedata[7:0] & WR_MASK;
    end
    if (avs_read && st.waitrequest) begin
      next_st.readdata = hit ? {APS_RD_PAD, st.sel} : '0;
    end
    // pins not claimed fall back to port logic
    next_st.pads.out = port_out;
    next_st.pads.oe_n = port_oe_n;
    rx_i = pick(st.sel[APS_BIT_RX], RX0, RX1);
    sdo_i = pick(st.sel[APS_BIT_SDO], SDO0, SPI_SERIAL_OUT);
    ss_i = pick(st.sel[APS_BIT_SS], SS0, SS1);
    tg_i = pick(st.sel[APS_BIT_T1G], PIN_RA4, PIN_RA3);
    tx_i = pick(st.sel[APS_BIT_TX], TX0, TX1);
    next_st.pads.out[sdo_i] = spi_sdo_out;
    next_st.pads.oe_n[sdo_i] = spi_sdo_oe_n;
    next_st.pads.out[tx_i] = serial_transmit_line_out;
    next_st.pads.oe_n[tx_i] = serial_transmit_line_oe_n;
    next_st.pads.out[rx_i] = serial_receive_line_out;
    next_st.pads.oe_n[rx_i] = serial_receive_line_oe_n;
    next_st.rx_in = pin_s[rx_i];
    next_st.tx_in = pin_s[tx_i];
    next_st.ss_in = pin_s[ss_i];
    next_st.t1g_in = pin_s[tg_i];
  end

  // state register
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      st <= '0;
      st.sel <= APS_SEL_RESET;
      st.waitrequest <= 1'b1;
      st.pads.oe_n <= '1;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state
  assign avs_readdata = st.readdata;
  assign avs_waitrequest = st.waitrequest;
  assign pads = st.pads;
  assign serial_receive_line_in = st.rx_in;
  assign serial_transmit_line_in = st.tx_in;
  assign spi_ss_in = st.ss_in;
  assign timer_gate_in = st.t1g_in;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_wr_taken;
    avs_write && !avs_waitrequest && hit && avs_byteenable[0];
  endsequence

  sequence s_sel_updated;
    st.sel == ($past(avs_writedata[7:0]) & WR_MASK);
  endsequence

  AST_WRITE_STORES: assert property (s_wr_taken |=> s_sel_updated)
    else $error("select register did not take masked write");
  AST_BIT4_ZERO: assert property (req && !avs_waitrequest |-> !avs_readdata[4])
    else $error("unimplemented bit read back as one");
  AST_ANSWER_BOUND: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered within one cycle");
  AST_RX_ROUTE: assert property (st.run && $past(st.run) |->
      pads.out[pick($past(st.sel[APS_BIT_RX]), RX0, RX1)] == $past(serial_receive_line_out))
    else $error("rx/data not on selected pin");
  AST_SDO_ROUTE: assert property (st.run && $past(st.run) |->
      pads.oe_n[pick($past(st.sel[APS_BIT_SDO]), SDO0, SPI_SERIAL_OUT)] == $past(spi_sdo_oe_n))
    else $error("spi data out not on selected pin");
  AST_LARGE_RO: assert property (SMALL_PKG == 0 |-> st.sel[APS_BIT_SDO] == 1'b0
      && st.sel[APS_BIT_SS] == 1'b0)
    else $error("read-only select bit set on large package");
  AST_SS_ROUTE: assert property (st.run |=>
      spi_ss_in == $past(pin_s[pick(st.sel[APS_BIT_SS], SS0, SS1)]))
    else $error("slave select not from selected pin");
  AST_T1G_ROUTE: assert property (st.run |=>
      timer_gate_in == $past(pin_s[st.sel[APS_BIT_T1G] ? PIN_RA3 : PIN_RA4]))
    else $error("timer gate not from selected pin");
  AST_TX_ROUTE: assert property (st.run && !st.sel[APS_BIT_TX] |=>
      pads.out[TX0] == $past(serial_transmit_line_out))
    else $error("transmit/clock not on default pin");
  AST_REVERT: assert property (SMALL_PKG == 1 && st.run && !st.sel[APS_BIT_SDO] |=>
      pads.out[PIN_RA4] == $past(port_out[PIN_RA4]))
    else $error("released pin did not revert to port logic");

  // read answer carries the stored select byte
  sequence s_rd_answer;
    avs_read && !avs_waitrequest && hit;
  endsequence

  AST_READ_ANSWER: assert property (s_rd_answer |-> avs_readdata == {APS_RD_PAD, st.sel})
    else $error("read answer differs from select register");
  // rx/data enable, spi data out level and alternate transmit/clock level land on the picked pin; released rx/data pin reverts
  AST_RX_OE: assert property (st.run |=>
      pads.oe_n[pick($past(st.sel[APS_BIT_RX]), RX0, RX1)] == $past(serial_receive_line_oe_n))
    else $error("rx/data enable not on selected pin");
  AST_SDO_OUT: assert property (st.run |=>
      pads.out[pick($past(st.sel[APS_BIT_SDO]), SDO0, SPI_SERIAL_OUT)] == $past(spi_sdo_out))
    else $error("spi data out level not on selected pin");
  AST_TX_ALT: assert property (st.run && st.sel[APS_BIT_TX] |=>
      pads.out[TX1] == $past(serial_transmit_line_out))
    else $error("transmit/clock not on alternate pin");
  AST_RX_REVERT: assert property (st.run && !st.sel[APS_BIT_RX] |=>
      pads.oe_n[RX1] == $past(port_oe_n[RX1]))
    else $error("released rx/data pin did not revert to port logic");

endmodule
`default_nettype wire

// >>> rtl/aps_pkg.sv
// shared constants and types for the alternate pin function select block
package aps_pkg;

  // ----------------------------------------
  // register map and field layout
  // ----------------------------------------
  localparam logic [3:0] APS_SEL_OFF = 4'h0; // byte address of the select register
  localparam logic [7:0] APS_SEL_RESET = 8'h00;
  localparam int APS_BIT_RX = 7;
  localparam int APS_BIT_SDO = 6;
  localparam int APS_BIT_SS = 5;
  localparam int APS_BIT_T1G = 3;
  localparam int APS_BIT_TX = 2;
  localparam logic [7:0] APS_MASK_SMALL = 8'hEC; // bits 7,6,5,3,2 writable
  localparam logic [7:0] APS_MASK_LARGE = 8'h8C; // bits 7,3,2 writable
  localparam logic [23:0] APS_RD_PAD = 24'h00_0000;

  // ----------------------------------------
  // pin indices into the pad vectors
  // ----------------------------------------
  localparam int APS_PIN_N = 12;
  localparam int PIN_RA0 = 0;
  localparam int PIN_RA1 = 1;
  localparam int PIN_RA3 = 2;
  localparam int PIN_RA4 = 3;
  localparam int PIN_RB5 = 4;
  localparam int PIN_RB7 = 5;
  localparam int PIN_RC2 = 6;
  localparam int PIN_RC3 = 7;
  localparam int PIN_RC4 = 8;
  localparam int PIN_RC5 = 9;
  localparam int PIN_RC6 = 10;
  localparam int PIN_RC7 = 11;

  // ----------------------------------------
  // carriers and state
  // ----------------------------------------
  typedef struct packed {
    logic [APS_PIN_N-1:0] out;
    logic [APS_PIN_N-1:0] oe_n;
  } aps_pads_t;

  typedef struct packed {
    logic [7:0] sel;
    logic waitrequest;
    logic [31:0] readdata;
    aps_pads_t pads;
    logic rx_in;
    logic tx_in;
    logic ss_in;
    logic t1g_in;
    logic run;
  } aps_state_t;

endpackage

// >>> rtl/aps_sync2.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module aps_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;

  // first stage is read only by the second
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// self-checking bench for the alternate pin select block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import aps_pkg::*;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  // pins: RA1, RA4, RC3, RC4 high; RA0, RA3, RC5 low
  logic [APS_PIN_N-1:0] pin_in = 12'h18A;
  logic [APS_PIN_N-1:0] port_out = 12'h000;
  logic [APS_PIN_N-1:0] port_oe_n = 12'hFFF;
  logic drv = 1'b1;
  logic drv_oe_n = 1'b0;
  aps_pads_t pads;
  logic serial_receive_line_in, serial_transmit_line_in, spi_ss_in, timer_gate_in;
  int error_cnt = 0;
  int checked = 0;

  // ----------------------------------------
  // clock and device
  // ----------------------------------------
  always #5 ref_clk = ~ref_clk;

  aps_top aps_top_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .pin_in(pin_in), .port_out(port_out), .port_oe_n(port_oe_n), .pads(pads),
    .serial_receive_line_out(drv), .serial_receive_line_oe_n(drv_oe_n), .serial_receive_line_in(serial_receive_line_in),
    .serial_transmit_line_out(drv), .serial_transmit_line_oe_n(drv_oe_n), .serial_transmit_line_in(serial_transmit_line_in),
    .spi_sdo_out(drv), .spi_sdo_oe_n(drv_oe_n),
    .spi_ss_in(spi_ss_in), .timer_gate_in(timer_gate_in)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one avalon transfer, held until waitrequest samples low
  task automatic bus(input logic rd, input logic [3:0] a, input logic [7:0] wd, input logic [3:0] be,
                     input logic [7:0] exp);
    avs_address <= a;
    avs_read <= rd;
    avs_write <= !rd;
    avs_writedata <= {24'h00_0000, wd};
    avs_byteenable <= be;
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    if (rd) chk(avs_readdata, {24'h00_0000, exp});
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge ref_clk);
  endtask

  // routing of every function for select pattern s (all set or all clear)
  task automatic route(input logic s);
    repeat (4) @(posedge ref_clk);
    chk(pads.oe_n[s ? PIN_RA1 : PIN_RC5], 0);
    chk(pads.out[s ? PIN_RA1 : PIN_RC5], 1);
    chk(pads.out[s ? PIN_RC5 : PIN_RA1], 0);
    chk(pads.oe_n[s ? PIN_RC5 : PIN_RA1], 1);
    chk(pads.out[s ? PIN_RA4 : PIN_RC2], 1);
    chk(pads.out[s ? PIN_RC2 : PIN_RA4], 0);
    chk(pads.out[PIN_RC4], !s);
    chk(serial_transmit_line_in, !s);
    chk(serial_receive_line_in, s);
    chk(spi_ss_in, !s);
    chk(timer_gate_in, !s);
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    bus(1, APS_SEL_OFF, 8'h00, 4'hF, 8'h00);
    route(0);
    bus(0, APS_SEL_OFF, 8'hFF, 4'hF, 8'h00);
    bus(1, APS_SEL_OFF, 8'h00, 4'hF, 8'hEC);
    bus(0, 4'h4, 8'h00, 4'hF, 8'h00);
    bus(0, APS_SEL_OFF, 8'h00, 4'hE, 8'h00);
    bus(1, 4'h4, 8'h00, 4'hF, 8'h00);
    bus(1, APS_SEL_OFF, 8'h00, 4'hF, 8'hEC);
    route(1);
    bus(0, APS_SEL_OFF, 8'h10, 4'hF, 8'h00);
    bus(1, APS_SEL_OFF, 8'h00, 4'hF, 8'h00);
    route(0);
    report_and_stop();
  end

  // watchdog against a hung handshake
  initial begin
    repeat (3000) @(posedge ref_clk);
    error_cnt++;
    report_and_stop();
  end
endmodule
`default_nettype wire
